// [verilog/lfwt_pkg.sv]
// constants, types and register map of the flash write target
// assumes a 100 MHz core clock that also samples the lpc pins
package lfwt_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ       = 100;
    localparam int PROG_TIME_NS  = 10_000;
    localparam int PROG_CYCLES   = PROG_TIME_NS * CLK_MHZ / 1000;
    localparam int ERASE_TIME_MS = 1000;
    localparam int ERASE_CYCLES  = ERASE_TIME_MS * CLK_MHZ * 1000;

    // ----------------------------------------------------------------
    // lpc nibbles and address layout
    // ----------------------------------------------------------------
    localparam logic [3:0] NIB_START   = 4'h0;
    localparam logic [3:0] NIB_ABORT   = 4'hf;
    localparam logic [3:0] NIB_SYNC    = 4'h0;
    localparam logic [3:0] NIB_TAR     = 4'hf;
    localparam logic [1:0] TYPE_MEM    = 2'h1;
    localparam int         DIR_BIT     = 1;
    localparam logic [2:0] ADDR_LAST   = 3'h7;
    localparam logic [7:0] ADDR_TOP    = 8'hff;
    localparam int         SPACE_BIT   = 22;
    localparam int         ID_HI_BIT   = 23;
    localparam int         ID_LO_BIT   = 19;
    localparam int         BLK_LO_BIT  = 16;
    localparam int         NUM_BLOCKS  = 8;
    localparam logic [2:0] TOP_BLOCK   = 3'h7;
    localparam logic [7:0] LOCK_RESET  = 8'hff;
    localparam logic [7:0] REG_READ    = 8'h00;

    // ----------------------------------------------------------------
    // avalon register map
    // ----------------------------------------------------------------
    localparam logic [3:0] OFF_LOCK    = 4'h0;
    localparam logic [3:0] OFF_STATUS  = 4'h4;
    localparam logic [3:0] OFF_ERASE   = 4'h8;
    localparam logic [3:0] OFF_WADDR   = 4'hc;
    localparam int         ERASE_GO    = 3;
    localparam int         ST_BUSY     = 0;
    localparam int         ST_ERASE    = 1;
    localparam int         ST_TOP_PIN  = 2;
    localparam int         ST_ARR_PIN  = 3;

    typedef enum logic [3:0] {
        S_IDLE, S_TYPE, S_ADDR, S_WLO, S_WHI, S_HTAR,
        S_DTAR, S_SYNC, S_RLO, S_RHI, S_BTAR, S_SKIP
    } lfwt_state_type;

    typedef struct packed {
        logic busy;
        logic erase;
        logic poll;
        logic toggle;
    } lfwt_eng_type;

endpackage : lfwt_pkg

// [verilog/lfwt_engine.sv]
// internal program / erase timer with completion status bits
// assumes go pulses only arrive while idle
`timescale 1ns/1ps
module lfwt_engine #(
    parameter int PROG_CYCLES  = lfwt_pkg::PROG_CYCLES,
    parameter int ERASE_CYCLES = lfwt_pkg::ERASE_CYCLES
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_prog_go,
    input  wire logic                  i_erase_go,
    input  wire logic                  i_data7,
    input  wire logic                  i_status_read,
    output lfwt_pkg::lfwt_eng_type     o_eng
);

    logic [31:0] cnt;
    wire         last = (cnt == 32'h0000_0001);

    // ----------------------------------------------------------------
    // operation timer
    // ----------------------------------------------------------------
    // reset clears busy at once: abort latency is zero cycles
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt   <= 32'h0000_0000;
            o_eng <= '0;
        end else if (i_prog_go) begin
            cnt         <= 32'(PROG_CYCLES);
            o_eng.busy  <= 1'b1;
            o_eng.erase <= 1'b0;
            o_eng.poll  <= ~i_data7;
        end else if (i_erase_go) begin
            cnt         <= 32'(ERASE_CYCLES);
            o_eng.busy  <= 1'b1;
            o_eng.erase <= 1'b1;
            o_eng.poll  <= 1'b0;
        end else if (o_eng.busy) begin
            cnt <= cnt - 32'h0000_0001;
            if (last) begin
                o_eng.busy <= 1'b0;
            end
            if (i_status_read) begin
                o_eng.toggle <= ~o_eng.toggle;
            end
        end
    end

    a_poll_program : assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        $rose(o_eng.busy) && !o_eng.erase |-> o_eng.poll == ~$past(i_data7))
        else $error("poll bit not complement of program data");

    a_poll_erase : assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_eng.busy && o_eng.erase |-> !o_eng.poll)
        else $error("poll bit not zero during erase");

    a_toggle_alt : assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_eng.busy && !last && i_status_read && !i_prog_go && !i_erase_go
        |=> o_eng.toggle != $past(o_eng.toggle))
        else $error("toggle bit did not alternate");

    a_toggle_stop : assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        !o_eng.busy && !i_prog_go && !i_erase_go |=> $stable(o_eng.toggle))
        else $error("toggle bit moved while idle");

endmodule : lfwt_engine

// [verilog/lfwt_target.sv]
// lpc memory write target: cycle decode, turnaround, sync, protection
// assumes lpc pins synchronous to i_core_clk; avalon master outside
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps

// How it works
// - start nibble with frame low begins a cycle; last start wins
// - type nibble: bits 3:2 must be 01, bit 1 write, bit 0 ignored
// - eight address nibbles assembled most significant first
// - data byte follows: low nibble first, then high nibble
// - device takes over the lines in clock fourteen on writes, clock twelve on reads
// - device drives sync zero in clock fifteen on writes, clock thirteen on reads
// - device drives ones in clock sixteen then floats; host resumes
// - every nibble sampled and driven valid at its own rising edge
// - address bit 22 picks array or register space; answer in range
// - identity bits not matching the strap: cycle silently ignored
// - top guard pin low blocks top block; high defers to lock
// - array guard pin protects other blocks independently
// - top protection is guard pin or lock bit
// - main protection is array guard pin or block lock bit
// - either reset pin low resets the device, same effect
// - reset deselects and floats the lad drivers
// - reset aborts a running program or erase quickly
// - completion shown by poll and toggle bits in lpc reads
// - frame low ends the cycle; abort returns to ready, op goes on
// - poll bit is complement on program, zero during erase
// - toggle bit alternates per read while busy, then stops
// - all write-lock bits come up set after reset
module lfwt_target #(
    parameter int PROG_CYCLES  = lfwt_pkg::PROG_CYCLES,
    parameter int ERASE_CYCLES = lfwt_pkg::ERASE_CYCLES
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_init_n,
    input  wire logic        i_lframe_n,
    input  wire logic [3:0]  i_lad,
    output logic      [3:0]  o_lad_out,
    output logic             o_lad_oe,
    input  wire logic        i_top_block_guard_n,
    input  wire logic        i_array_guard_n,
    input  wire logic [3:0]  i_strap_code,
    input  wire logic [7:0]  i_array_rdata,
    output logic      [18:0] o_array_addr,
    output logic      [7:0]  o_prog_data,
    output logic             o_prog_start,
    output logic             o_erase_start,
    output logic      [2:0]  o_erase_block,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output wire logic        o_avs_waitrequest
);

    // ----------------------------------------------------------------
    // reset
    // ----------------------------------------------------------------
    // both pins merged
    wire rst_n = i_resetn & i_init_n;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic blk_protect(
        input logic [2:0] blk,
        input logic [7:0] lock,
        input logic       top_n,
        input logic       arr_n
    );
        if (blk == lfwt_pkg::TOP_BLOCK) begin
            blk_protect = !top_n || lock[blk];
        end else begin
            blk_protect = !arr_n || lock[blk];
        end
    endfunction : blk_protect

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    lfwt_pkg::lfwt_state_type state;
    lfwt_pkg::lfwt_state_type next_state;
    lfwt_pkg::lfwt_eng_type   eng;
    logic [2:0]  cnt;
    logic [2:0]  next_cnt;
    logic [31:0] addr;
    logic [31:0] next_addr;
    logic [7:0]  wdata;
    logic [7:0]  next_wdata;
    logic        dir;
    logic        next_dir;
    logic [7:0]  rd_byte;
    logic [7:0]  lock;
    logic [31:0] last_waddr;
    logic        ack;
    logic        next_oe;
    logic [3:0]  next_out;
    logic        erase_go;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire [31:0] addr_full = {addr[27:0], i_lad};
    // identity bits are the inverse of the strap
    wire id_ok = (addr_full[lfwt_pkg::ID_HI_BIT] == ~i_strap_code[3])
              && (addr_full[lfwt_pkg::ID_HI_BIT-2:lfwt_pkg::ID_LO_BIT]
                  == ~i_strap_code[2:0]);
    wire hit      = (addr_full[31:24] == lfwt_pkg::ADDR_TOP) && id_ok;
    wire mem_sp   = addr[lfwt_pkg::SPACE_BIT];
    wire [2:0] blk = addr[lfwt_pkg::BLK_LO_BIT+2:lfwt_pkg::BLK_LO_BIT];
    wire is_start = !i_lframe_n && (i_lad == lfwt_pkg::NIB_START);
    wire type_ok  = (i_lad[3:2] == lfwt_pkg::TYPE_MEM);
    wire addr_end = (state == lfwt_pkg::S_ADDR)
                 && (cnt == lfwt_pkg::ADDR_LAST);
    wire prot     = blk_protect(blk, lock, i_top_block_guard_n,
                                i_array_guard_n);
    // register space writes are answered but change nothing
    wire prog_go  = (state == lfwt_pkg::S_SYNC) && dir && mem_sp
                 && !eng.busy && !prot;
    // every read reloads the byte, so register reads never show stale data
    wire rd_load  = (state == lfwt_pkg::S_DTAR) && !dir;
    wire stat_rd  = rd_load && mem_sp;
    // status replaces data while an operation runs
    wire [7:0] stat_byte = {eng.poll, eng.toggle, 6'h00};
    wire [7:0] rd_val = !mem_sp   ? lfwt_pkg::REG_READ :
                        eng.busy  ? stat_byte : i_array_rdata;

    // ----------------------------------------------------------------
    // lpc cycle sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_addr  = addr;
        next_wdata = wdata;
        next_dir   = dir;
        case (state)
            lfwt_pkg::S_IDLE: begin
                next_state = lfwt_pkg::S_IDLE;
            end
            lfwt_pkg::S_SKIP: begin
                next_state = lfwt_pkg::S_SKIP;
            end
            lfwt_pkg::S_TYPE: begin
                next_cnt = 3'h0;
                if (type_ok) begin
                    next_dir   = i_lad[lfwt_pkg::DIR_BIT];
                    next_state = lfwt_pkg::S_ADDR;
                end else begin
                    // unknown type, stay off the bus
                    next_state = lfwt_pkg::S_SKIP;
                end
            end
            lfwt_pkg::S_ADDR: begin
                next_addr = addr_full;
                next_cnt  = cnt + 3'h1;
                if (cnt == lfwt_pkg::ADDR_LAST) begin
                    if (!hit) begin
                        next_state = lfwt_pkg::S_SKIP;
                    end else if (dir) begin
                        next_state = lfwt_pkg::S_WLO;
                    end else begin
                        next_state = lfwt_pkg::S_HTAR;
                    end
                end
            end
            lfwt_pkg::S_WLO: begin
                next_wdata = {wdata[7:4], i_lad};
                next_state = lfwt_pkg::S_WHI;
            end
            lfwt_pkg::S_WHI: begin
                next_wdata = {i_lad, wdata[3:0]};
                next_state = lfwt_pkg::S_HTAR;
            end
            lfwt_pkg::S_HTAR: begin
                next_state = lfwt_pkg::S_DTAR;
            end
            lfwt_pkg::S_DTAR: begin
                next_state = lfwt_pkg::S_SYNC;
            end
            lfwt_pkg::S_SYNC: begin
                next_state = dir ? lfwt_pkg::S_BTAR : lfwt_pkg::S_RLO;
            end
            lfwt_pkg::S_RLO: begin
                next_state = lfwt_pkg::S_RHI;
            end
            lfwt_pkg::S_RHI: begin
                next_state = lfwt_pkg::S_BTAR;
            end
            lfwt_pkg::S_BTAR: begin
                next_state = lfwt_pkg::S_IDLE;
            end
            default: begin
                next_state = lfwt_pkg::S_IDLE;
            end
        endcase
        if (!i_lframe_n) begin
            next_state = is_start ? lfwt_pkg::S_TYPE : lfwt_pkg::S_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // lad drive, registered so it is stable at each edge
    // ----------------------------------------------------------------
    // values launched one edge ahead
    assign next_oe = (next_state == lfwt_pkg::S_DTAR)
                  || (next_state == lfwt_pkg::S_SYNC)
                  || (next_state == lfwt_pkg::S_RLO)
                  || (next_state == lfwt_pkg::S_RHI)
                  || (next_state == lfwt_pkg::S_BTAR);
    assign next_out = (next_state == lfwt_pkg::S_SYNC) ? lfwt_pkg::NIB_SYNC
                    : (next_state == lfwt_pkg::S_RLO)  ? rd_byte[3:0]
                    : (next_state == lfwt_pkg::S_RHI)  ? rd_byte[7:4]
                    : lfwt_pkg::NIB_TAR;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= lfwt_pkg::S_IDLE;
            cnt       <= 3'h0;
            addr      <= 32'h0000_0000;
            wdata     <= 8'h00;
            dir       <= 1'b0;
            o_lad_oe  <= 1'b0;
            o_lad_out <= lfwt_pkg::NIB_TAR;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            addr      <= next_addr;
            wdata     <= next_wdata;
            dir       <= next_dir;
            o_lad_oe  <= next_oe;
            o_lad_out <= next_out;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_byte      <= 8'h00;
            o_array_addr <= 19'h0_0000;
            o_prog_data  <= 8'h00;
            o_prog_start <= 1'b0;
            last_waddr   <= 32'h0000_0000;
        end else begin
            if (addr_end) begin
                o_array_addr <= addr_full[18:0];
            end
            if (rd_load) begin
                rd_byte <= rd_val;
            end
            o_prog_start <= prog_go;
            if (prog_go) begin
                o_prog_data <= wdata;
                last_waddr  <= addr;
            end
        end
    end

    lfwt_engine #(
        .PROG_CYCLES  (PROG_CYCLES),
        .ERASE_CYCLES (ERASE_CYCLES)
    ) u_engine (
        .i_core_clk    (i_core_clk),
        .i_resetn      (rst_n),
        .i_prog_go     (prog_go),
        .i_erase_go    (erase_go),
        .i_data7       (wdata[7]),
        .i_status_read (stat_rd && eng.busy),
        .o_eng         (eng)
    );

    // ----------------------------------------------------------------
    // avalon slave, one wait cycle on every access
    // ----------------------------------------------------------------
    wire req      = i_avs_read || i_avs_write;
    wire wr_take  = i_avs_write && ack;
    wire [2:0] er_blk = i_avs_writedata[2:0];
    wire er_prot  = blk_protect(er_blk, lock, i_top_block_guard_n,
                                i_array_guard_n);
    assign erase_go = wr_take && (i_avs_address == lfwt_pkg::OFF_ERASE)
                 && i_avs_writedata[lfwt_pkg::ERASE_GO]
                 && !eng.busy && !er_prot && !prog_go;
    wire [31:0] st_word = {28'h000_0000, !i_array_guard_n,
                           !i_top_block_guard_n, eng.erase, eng.busy};
    wire [31:0] rd_mux =
        (i_avs_address == lfwt_pkg::OFF_LOCK)   ? {24'h00_0000, lock} :
        (i_avs_address == lfwt_pkg::OFF_STATUS) ? st_word :
        (i_avs_address == lfwt_pkg::OFF_WADDR)  ? last_waddr :
        32'h0000_0000;

    assign o_avs_waitrequest = req && !ack;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack            <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
            lock           <= lfwt_pkg::LOCK_RESET;
            o_erase_start  <= 1'b0;
            o_erase_block  <= 3'h0;
        end else begin
            ack <= req && !ack;
            if (i_avs_read && !ack) begin
                o_avs_readdata <= rd_mux;
            end
            if (wr_take && (i_avs_address == lfwt_pkg::OFF_LOCK)) begin
                lock <= i_avs_writedata[lfwt_pkg::NUM_BLOCKS-1:0];
            end
            o_erase_start <= erase_go;
            if (erase_go) begin
                o_erase_block <= er_blk;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_start_last : assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        is_start |=> state == lfwt_pkg::S_TYPE)
        else $error("start nibble not taken");

    a_abort_ready : assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        !i_lframe_n && !is_start |=> state == lfwt_pkg::S_IDLE && !o_lad_oe)
        else $error("frame low did not end the cycle");

    a_addr_order : assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        state == lfwt_pkg::S_ADDR && i_lframe_n
        |=> addr[3:0] == $past(i_lad) && addr[7:4] == $past(addr[3:0]))
        else $error("address nibble order wrong");

    a_turn_sync : assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        state == lfwt_pkg::S_HTAR && i_lframe_n
        |=> o_lad_oe && o_lad_out == lfwt_pkg::NIB_TAR)
        else $error("no takeover in turnaround");

    a_sync_zero : assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        state == lfwt_pkg::S_DTAR && i_lframe_n
        |=> o_lad_oe && o_lad_out == lfwt_pkg::NIB_SYNC)
        else $error("sync nibble not zero");

    a_bus_release : assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        state == lfwt_pkg::S_BTAR && o_lad_oe
        |-> o_lad_out == lfwt_pkg::NIB_TAR ##1 !o_lad_oe)
        else $error("lad not released after turnaround");

    a_bad_type : assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        state == lfwt_pkg::S_TYPE && !type_ok && i_lframe_n
        |=> !o_lad_oe && state == lfwt_pkg::S_SKIP)
        else $error("unknown type not ignored");

    a_id_quiet : assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        addr_end && !id_ok && i_lframe_n
        |=> state == lfwt_pkg::S_SKIP && !o_lad_oe)
        else $error("foreign id answered");

    a_top_guard : assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        prog_go && blk == lfwt_pkg::TOP_BLOCK
        |-> i_top_block_guard_n && !lock[lfwt_pkg::TOP_BLOCK])
        else $error("protected top block programmed");

    a_main_guard : assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        prog_go && blk != lfwt_pkg::TOP_BLOCK
        |-> i_array_guard_n && !lock[blk])
        else $error("protected main block programmed");

    a_bus_answer : assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("avalon answer late");

endmodule : lfwt_target

// [bench/lfwt_host.sv]
// lpc host model: frame, nibbles, turnaround capture
// assumes the device drives lad from registers on the same clock
`timescale 1ns/1ps
module lfwt_host (
    input  wire logic       i_core_clk,
    input  wire logic       i_dev_oe,
    input  wire logic [3:0] i_dev_lad,
    output logic            o_lframe_n,
    output logic      [3:0] o_lad
);
    logic       host_oe  = 1'b0;
    logic [3:0] host_lad = 4'hf;
    assign o_lad = i_dev_oe ? i_dev_lad : (host_oe ? host_lad : 4'hf);
    initial o_lframe_n = 1'b1;
    // --------------------------
    // one cycle, start to clock 17
    // --------------------------
    task automatic cycle(input logic [3:0] t, input logic [31:0] a,
                         input logic [7:0] d, output logic [15:0] seen);
        logic [3:0] nib [0:12];
        // start, type, address msb first, data lo hi
        nib[0] = 4'h0;
        nib[1] = t;
        for (int i = 0; i < 8; i++) nib[2+i] = a[31-4*i -: 4];
        nib[10] = t[1] ? d[3:0] : 4'hf;
        nib[11] = d[7:4];
        nib[12] = 4'hf;
        for (int k = 0; k < 13; k++) begin
            // read: host lets go after its turnaround clock 11
            host_oe    <= t[1] || (k < 11);
            host_lad   <= nib[k];
            o_lframe_n <= (k != 0);
            @(posedge i_core_clk);
        end
        host_oe <= 1'b0;
        // seen = oe of clocks 14..17, then lad of clocks 14..16
        for (int k = 0; k < 4; k++) begin
            @(posedge i_core_clk);
            seen[15-k] = i_dev_oe;
            if (k < 3) seen[4*(2-k) +: 4] = o_lad;
        end
    endtask : cycle
endmodule : lfwt_host

// [bench/lfwt_target_tb.sv]
// bench: lpc write cycles, guards and lock register over avalon
// assumes lfwt_host on the lpc pins; short program count of 10
`timescale 1ns/1ps
module lfwt_target_tb;
    logic        clk      = 1'b0;
    logic        resetn   = 1'b0;
    logic        init_n   = 1'b1;
    logic        top_n    = 1'b1;
    logic        arr_n    = 1'b1;
    logic [3:0]  strap    = 4'h0;
    logic [3:0]  av_addr  = 4'h0;
    logic        av_rd    = 1'b0;
    logic        av_wr    = 1'b0;
    logic [31:0] av_wdata = 32'h0000_0000;
    logic [31:0] av_rdata, q;
    logic [18:0] arr_addr;
    logic [7:0]  prog_data;
    logic [3:0]  lad, lad_out;
    logic [2:0]  er_blk;
    logic [15:0] seen_r;
    logic        lframe_n, lad_oe, prog_start, av_wait, er_start;
    int          err_count  = 0;
    int          num_checks = 0;
    int          prog_cnt   = 0;
    int          erase_cnt  = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (prog_start === 1'b1) prog_cnt <= prog_cnt + 1;
        if (er_start === 1'b1) erase_cnt <= erase_cnt + 1;
    end
    // erase long enough to poll it twice over lpc
    lfwt_target #(.PROG_CYCLES(10), .ERASE_CYCLES(200)) dut_u (
        .i_core_clk(clk), .i_resetn(resetn), .i_init_n(init_n),
        .i_lframe_n(lframe_n), .i_lad(lad), .o_lad_out(lad_out),
        .o_lad_oe(lad_oe), .i_top_block_guard_n(top_n),
        .i_array_guard_n(arr_n), .i_strap_code(strap),
        .i_array_rdata(8'hff), .o_array_addr(arr_addr),
        .o_prog_data(prog_data), .o_prog_start(prog_start),
        .o_erase_start(er_start), .o_erase_block(er_blk),
        .i_avs_address(av_addr),
        .i_avs_read(av_rd), .i_avs_write(av_wr),
        .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata),
        .o_avs_waitrequest(av_wait));
    lfwt_host host_u (.i_core_clk(clk), .i_dev_oe(lad_oe),
        .i_dev_lad(lad_out), .o_lframe_n(lframe_n), .o_lad(lad));
    // --------------------------
    // shared tasks
    // --------------------------
    task automatic end_sim();
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic check(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic av_req(input logic w, input logic [3:0] a,
                          input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        av_addr  <= a;
        av_wdata <= d;
        av_wr    <= w;
        av_rd    <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (av_wait !== 1'b0 && n < 50);
        r = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        if (n >= 50) err_count++;
        @(posedge clk);
    endtask : av_req
    // engine needs 10 cycles; 20 idle cycles keep programs apart
    task automatic run(input logic [3:0] t, input logic [31:0] a,
                       input logic tp, ar, input logic [3:0] s,
                       input logic [15:0] es, input int en);
        logic [15:0] seen;
        int          c0;
        top_n <= tp;
        arr_n <= ar;
        strap <= s;
        c0 = prog_cnt;
        @(posedge clk);
        host_u.cycle(t, a, 8'h5a, seen);
        repeat (20) @(posedge clk);
        check("turnaround", {16'h0000, seen}, {16'h0000, es});
        check("program", 32'(prog_cnt - c0), 32'(en));
    endtask : run
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        av_req(1'b0, lfwt_pkg::OFF_LOCK, 32'h0000_0000, q);
        check("lock", q, 32'h0000_00ff);
        av_req(1'b1, lfwt_pkg::OFF_LOCK, 32'h0000_0000, q);
        run(4'h6, 32'hffff_1234, 1, 1, 4'h0, 16'hef0f, 1);
        check("addr", {13'h0000, arr_addr}, 32'h0007_1234);
        check("data", {24'h00_0000, prog_data}, 32'h0000_005a);
        run(4'h7, 32'hffff_0000, 0, 1, 4'h0, 16'hef0f, 0);
        run(4'h7, 32'hfff8_0000, 1, 0, 4'h0, 16'hef0f, 0);
        run(4'h6, 32'hfff8_0000, 0, 1, 4'h0, 16'hef0f, 1);
        run(4'h6, 32'hffbf_0000, 1, 1, 4'h0, 16'hef0f, 0);
        run(4'h6, 32'hffff_0000, 1, 1, 4'h1, 16'h0fff, 0);
        run(4'h2, 32'hffff_0000, 1, 1, 4'h0, 16'h0fff, 0);
        av_req(1'b1, lfwt_pkg::OFF_ERASE, 32'h0000_0009, q);
        av_req(1'b0, lfwt_pkg::OFF_STATUS, 32'h0000_0000, q);
        check("status", q, 32'h0000_0003);
        check("erase", 32'(erase_cnt), 32'h0000_0001);
        check("erase blk", {29'h0000_0000, er_blk}, 32'h0000_0001);
        run(4'h4, 32'hffff_0000, 1, 1, 4'h0, 16'he00f, 0);
        run(4'h4, 32'hffff_0000, 1, 1, 4'h0, 16'he04f, 0);
        repeat (200) @(posedge clk);
        run(4'h4, 32'hffff_0000, 1, 1, 4'h0, 16'hefff, 0);
        run(4'h4, 32'hffbf_0000, 1, 1, 4'h0, 16'he00f, 0);
        // reset in the middle of a read
        fork
            host_u.cycle(4'h4, 32'hffff_0000, 8'h00, seen_r);
            begin
                repeat (13) @(posedge clk);
                init_n <= 1'b0;
            end
        join
        check("reset float", {16'h0000, seen_r}, 32'h0000_0fff);
        init_n <= 1'b0;
        repeat (2) @(posedge clk);
        check("oe", {31'h0000_0000, lad_oe}, 32'h0000_0000);
        init_n <= 1'b1;
        @(posedge clk);
        av_req(1'b0, lfwt_pkg::OFF_LOCK, 32'h0000_0000, q);
        check("lock init", q, 32'h0000_00ff);
        run(4'h6, 32'hfff8_0000, 1, 1, 4'h0, 16'hef0f, 0);
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        end_sim();
    end
endmodule : lfwt_target_tb
